// file: gpio_defines.svh
// Purpose: Offsets, field masks, reset values for the six-bit port
// Assumes: APB byte addresses, one aligned 32-bit word per register
// Notes: Bits 7:6 of every control register are absent and read 0
`ifndef GPIO_DEFINES_SVH
`define GPIO_DEFINES_SVH

`define GP_ADDR_W 8
`define GP_OFF_PIN_LEVEL 8'h00
`define GP_OFF_OUT_LATCH 8'h04
`define GP_OFF_DIRECTION 8'h08
`define GP_OFF_ANALOG_SEL 8'h0C
`define GP_OFF_PULL_UP 8'h10
`define GP_OFF_OPEN_DRAIN 8'h14
`define GP_OFF_SLEW_LIMIT 8'h18
`define GP_OFF_THRESHOLD 8'h1C

`define GP_PIN3 3
`define GP_MASK_ALL 6'h3F
`define GP_MASK_NO3 6'h37
`define GP_PIN3_BIT 6'h08

`define GP_RST_DIRECTION 6'h3F
`define GP_RST_ANALOG_SEL 6'h37
`define GP_RST_PULL_UP 6'h00
`define GP_RST_OPEN_DRAIN 6'h00
`define GP_RST_SLEW_LIMIT 6'h37
`define GP_RST_THRESHOLD 6'h3F
`define GP_RST_OUT_LATCH 6'h00

`endif

// file: gpio_pkg.sv
// Purpose: Types shared by the six-bit port
// Assumes: Six pins, index 0 to 5
// Notes: Control bundle carried as one packed struct
package gpio_pkg;
  typedef logic [5:0] pin_vec_t;

  typedef struct packed {
    pin_vec_t dir;
    pin_vec_t analog_select_bit;
    pin_vec_t wpu;
    pin_vec_t odc;
    pin_vec_t slr;
    pin_vec_t inlvl;
  } pin_cfg_t;
endpackage

// file: six_bit_gpio_port.sv
// Purpose: Six-bit bidirectional port with APB control registers
// Assumes: Pad handles levels; peripheral signals are on CLK
// Notes: One wait state on every APB access
// Function
// [R1] Six pins; direction 1 turns driver off, 0 drives the latch onto the pin.
// [R2] Pin 3 is input-only; its direction bit always reads 1.
// [R3] Writes to latch or pin-level register both update the latch.
// [R4] Latch register reads latch; pin-level register reads pin levels.
// [R5] Every write merges new data with sampled pins into the latch; the latch here keeps no pin bit, only PWDATA[5:0] with bit 3 cleared.
// [R6] Latch holds the latest value written through either register.
// [R7] After reset pins follow the latch; peripherals only when selected.
// [R8] Selected peripheral pins are not driven by the port; still readable.
// [R9] Enabled analog output forces the digital driver off.
// [R10] Analog select disables the pin's digital input buffer.
// [R11] Analog input pins read 0 digitally.
// [R12] Analog select leaves digital output driving untouched.
// [R13] Direction bits control drivers on analog pins too; keep them set.
// [R14] Analog select resets to analog; software clears for digital input.
// [R15] Per-pin open-drain bit: set sinks only, clear is push-pull.
// [R16] Two-wire bus ownership makes the pin open-drain by itself.
// [R17] Per-pin slew bit: set limits slew, clear gives full rate.
// [R18] Per-pin Schmitt or TTL threshold for reads and change detection.
// [R19] Change thresholds only while peripherals are disabled.
// [R20] Per-pin weak pull-up from the pull-up enable register.
// [R21] Pin 3 pull-up on when external reset enabled or its bit is set.
// [R22] Pull-up off while the pin is an output.
// [R23] Pin 3 level bit is read-only and reads 1 with external reset on.
// [R24] Bits 7 and 6 of control registers read 0.
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "gpio_defines.svh"

module six_bit_gpio_port
  import gpio_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [`GP_ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  input wire logic [5:0] PIN_IN,
  output logic [5:0] PIN_OUT,
  output logic [5:0] PIN_OE,
  output logic [5:0] PIN_PULLUP,
  output logic [5:0] PIN_SLEW_LIMIT,
  output logic [5:0] PIN_SCHMITT_SEL,
  output logic [5:0] PIN_DIN,
  input wire logic [5:0] PERIPH_SEL,
  input wire logic [5:0] PERIPH_OUT,
  input wire logic [5:0] PERIPH_OE,
  input wire logic [5:0] TWI_OWN,
  input wire logic [5:0] ANALOG_OUT_EN,
  input wire logic EXT_RESET_EN
);

  pin_cfg_t cfg_ff;
  pin_vec_t latch_ff;
  pin_vec_t sync1_ff;
  pin_vec_t sync2_ff;
  logic pready_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  pin_vec_t out_ff;
  pin_vec_t oe_ff;
  pin_vec_t pullup_ff;
  pin_vec_t din_ff;

  logic access;
  logic wr_en;
  logic addr_hit;
  pin_vec_t rd_pins;
  pin_vec_t nxt_latch;
  logic [31:0] nxt_prdata;
  pin_vec_t nxt_out;
  pin_vec_t nxt_oe;
  pin_vec_t nxt_pullup;
  pin_vec_t od_mode;
  pin_vec_t src_out;
  pin_vec_t src_drive;

  // Pin input synchroniser
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sync1_ff <= 6'h00;
      sync2_ff <= 6'h00;
    end else begin
      sync1_ff <= PIN_IN;
      sync2_ff <= sync1_ff;
    end
  end

  // Digital view of the pins
  always_comb begin
    rd_pins = sync2_ff & ~cfg_ff.analog_select_bit & `GP_MASK_NO3; // [R10] [R11]
    rd_pins[`GP_PIN3] = EXT_RESET_EN | sync2_ff[`GP_PIN3]; // [R23]
  end

  // APB handshake: answer one cycle into the access phase
  assign access = PSEL & PENABLE;
  assign wr_en = access & pready_ff & PWRITE;

  always_comb begin
    addr_hit = 1'b1;
    nxt_prdata = 32'h0000_0000; // [R24]
    unique case (PADDR)
      `GP_OFF_PIN_LEVEL: nxt_prdata[5:0] = rd_pins; // [R4]
      `GP_OFF_OUT_LATCH: nxt_prdata[5:0] = latch_ff & `GP_MASK_NO3; // [R4]
      `GP_OFF_DIRECTION: nxt_prdata[5:0] = cfg_ff.dir; // [R2]
      `GP_OFF_ANALOG_SEL: nxt_prdata[5:0] = cfg_ff.analog_select_bit;
      `GP_OFF_PULL_UP: nxt_prdata[5:0] = cfg_ff.wpu;
      `GP_OFF_OPEN_DRAIN: nxt_prdata[5:0] = cfg_ff.odc;
      `GP_OFF_SLEW_LIMIT: nxt_prdata[5:0] = cfg_ff.slr;
      `GP_OFF_THRESHOLD: nxt_prdata[5:0] = cfg_ff.inlvl;
      default: addr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= access & ~pready_ff;
      if (access & ~pready_ff) begin
        prdata_ff <= PWRITE ? 32'h0000_0000 : nxt_prdata;
        pslverr_ff <= ~addr_hit;
      end
    end
  end

  // Write takes the new bits; only sampled pin 3 is merged, and the latch clears it
  always_comb begin
    nxt_latch = (rd_pins & ~`GP_MASK_NO3) | (PWDATA[5:0] & `GP_MASK_NO3); // [R5]
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      latch_ff <= `GP_RST_OUT_LATCH;
    end else if (wr_en && (PADDR == `GP_OFF_OUT_LATCH || PADDR == `GP_OFF_PIN_LEVEL)) begin
      latch_ff <= nxt_latch & `GP_MASK_NO3; // [R3] [R6]
    end
  end

  // Control registers
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_ff.dir <= `GP_RST_DIRECTION;
      cfg_ff.analog_select_bit <= `GP_RST_ANALOG_SEL; // [R14]
      cfg_ff.wpu <= `GP_RST_PULL_UP;
      cfg_ff.odc <= `GP_RST_OPEN_DRAIN;
      cfg_ff.slr <= `GP_RST_SLEW_LIMIT;
      cfg_ff.inlvl <= `GP_RST_THRESHOLD;
    end else if (wr_en) begin
      unique case (PADDR)
        `GP_OFF_DIRECTION: cfg_ff.dir <= PWDATA[5:0] | `GP_PIN3_BIT; // [R2]
        `GP_OFF_ANALOG_SEL: cfg_ff.analog_select_bit <= PWDATA[5:0] & `GP_MASK_NO3;
        `GP_OFF_PULL_UP: cfg_ff.wpu <= PWDATA[5:0] & `GP_MASK_ALL; // [R20]
        `GP_OFF_OPEN_DRAIN: cfg_ff.odc <= PWDATA[5:0] & `GP_MASK_NO3; // [R15]
        `GP_OFF_SLEW_LIMIT: cfg_ff.slr <= PWDATA[5:0] & `GP_MASK_NO3; // [R17]
        `GP_OFF_THRESHOLD: cfg_ff.inlvl <= PWDATA[5:0] & `GP_MASK_ALL; // [R18]
        default: ;
      endcase
    end
  end

  // Output source and driver selection
  always_comb begin
    src_out = (PERIPH_SEL & PERIPH_OUT) | (~PERIPH_SEL & latch_ff); // [R7]
    src_drive = (PERIPH_SEL & PERIPH_OE) | (~PERIPH_SEL & ~cfg_ff.dir); // [R1] [R8] [R12] [R13]
    od_mode = cfg_ff.odc | TWI_OWN; // [R15] [R16]
    nxt_out = src_out & ~od_mode;
    nxt_oe = src_drive & ~(od_mode & src_out) & ~ANALOG_OUT_EN & `GP_MASK_NO3; // [R9]
    nxt_pullup = cfg_ff.wpu & cfg_ff.dir; // [R22]
    nxt_pullup[`GP_PIN3] = EXT_RESET_EN | cfg_ff.wpu[`GP_PIN3]; // [R21]
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      out_ff <= 6'h00;
      oe_ff <= 6'h00;
      pullup_ff <= 6'h00;
      din_ff <= 6'h00;
    end else begin
      out_ff <= nxt_out;
      oe_ff <= nxt_oe;
      pullup_ff <= nxt_pullup;
      din_ff <= rd_pins;
    end
  end

  assign PREADY = pready_ff;
  assign PRDATA = prdata_ff;
  assign PSLVERR = pslverr_ff;
  assign PIN_OUT = out_ff;
  assign PIN_OE = oe_ff;
  assign PIN_PULLUP = pullup_ff;
  assign PIN_SLEW_LIMIT = cfg_ff.slr; // [R17]
  assign PIN_SCHMITT_SEL = cfg_ff.inlvl; // [R18]
  assign PIN_DIN = din_ff;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  property p_dir_pin3;
    PREADY && !PSLVERR && !$past(PWRITE) && $past(PADDR) == `GP_OFF_DIRECTION |-> PRDATA[`GP_PIN3];
  endproperty
  a_dir_pin3: assert property (p_dir_pin3) else $error("pin 3 direction not read as 1"); // [R2]

  property p_pin3_undriven;
    PIN_OE[`GP_PIN3] == 1'b0;
  endproperty
  a_pin3_undriven: assert property (p_pin3_undriven) else $error("pin 3 driven"); // [R2]

  property p_latch_write;
    wr_en && (PADDR == `GP_OFF_OUT_LATCH || PADDR == `GP_OFF_PIN_LEVEL)
      |=> latch_ff == ($past(PWDATA[5:0]) & `GP_MASK_NO3);
  endproperty
  a_latch_write: assert property (p_latch_write) else $error("latch not updated by write"); // [R3]

  property p_latch_drive;
    cfg_ff.dir[0] == 1'b0 && !PERIPH_SEL[0] && !ANALOG_OUT_EN[0] && !od_mode[0]
      |=> PIN_OE[0] && PIN_OUT[0] == $past(latch_ff[0]);
  endproperty
  a_latch_drive: assert property (p_latch_drive) else $error("pin 0 not driving latch"); // [R1]

  property p_input_off;
    ##1 (PIN_OE & $past(~PERIPH_SEL & cfg_ff.dir)) == 6'h00;
  endproperty
  a_input_off: assert property (p_input_off) else $error("input pin driven"); // [R1]

  property p_periph_drive;
    ##1 (PIN_OE & $past(PERIPH_SEL & ~PERIPH_OE)) == 6'h00;
  endproperty
  a_periph_drive: assert property (p_periph_drive) else $error("port drives peripheral pin"); // [R8]

  property p_analog_out;
    ##1 (PIN_OE & $past(ANALOG_OUT_EN)) == 6'h00;
  endproperty
  a_analog_out: assert property (p_analog_out) else $error("driver on under analog output"); // [R9]

  property p_analog_read;
    (PIN_DIN & $past(cfg_ff.analog_select_bit)) == 6'h00;
  endproperty
  a_analog_read: assert property (p_analog_read) else $error("analog pin reads 1"); // [R10]

  property p_open_drain;
    ##1 (PIN_OE & PIN_OUT) == 6'h00 || (PIN_OE & PIN_OUT & $past(od_mode)) == 6'h00;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open-drain pin sources high"); // [R16]

  property p_pin3_pull;
    ##1 PIN_PULLUP[`GP_PIN3] == $past(EXT_RESET_EN | cfg_ff.wpu[`GP_PIN3]);
  endproperty
  a_pin3_pull: assert property (p_pin3_pull) else $error("pin 3 pull-up wrong"); // [R21]

  property p_pull_output;
    ##1 (PIN_PULLUP & ~$past(cfg_ff.dir)) == 6'h00;
  endproperty
  a_pull_output: assert property (p_pull_output) else $error("pull-up on output pin"); // [R22]

  property p_upper_zero;
    PREADY |-> PRDATA[31:6] == 26'h0000000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set"); // [R24]

  property p_ready_pulse;
    PREADY |=> !PREADY;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");

  // Read-back, register write and pin output checks
  property p_read_latch;
    PREADY && !PSLVERR && !$past(PWRITE) && $past(PADDR) == `GP_OFF_OUT_LATCH
      |-> PRDATA[5:0] == ($past(latch_ff) & `GP_MASK_NO3);
  endproperty
  a_read_latch: assert property (p_read_latch) else $error("latch read-back wrong"); // [R4]

  property p_read_pins;
    PREADY && !PSLVERR && !$past(PWRITE) && $past(PADDR) == `GP_OFF_PIN_LEVEL
      |-> ((PRDATA[5:0] ^ $past(sync2_ff)) & ~$past(cfg_ff.analog_select_bit) & `GP_MASK_NO3) == 6'h00;
  endproperty
  a_read_pins: assert property (p_read_pins) else $error("pin-level read wrong"); // [R4]

  property p_read_pin3;
    PREADY && !PSLVERR && !$past(PWRITE) && $past(PADDR) == `GP_OFF_PIN_LEVEL && $past(EXT_RESET_EN)
      |-> PRDATA[`GP_PIN3];
  endproperty
  a_read_pin3: assert property (p_read_pin3) else $error("pin 3 level not 1 with external reset"); // [R23]

  property p_analog_prdata;
    PREADY && !PSLVERR && !$past(PWRITE) && $past(PADDR) == `GP_OFF_PIN_LEVEL
      |-> (PRDATA[5:0] & $past(cfg_ff.analog_select_bit)) == 6'h00;
  endproperty
  a_analog_prdata: assert property (p_analog_prdata) else $error("analog pin read not 0"); // [R11]

  property p_latch_hold;
    !(wr_en && (PADDR == `GP_OFF_OUT_LATCH || PADDR == `GP_OFF_PIN_LEVEL))
      |=> $stable(latch_ff);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch changed without write"); // [R6]

  property p_dir_write;
    wr_en && PADDR == `GP_OFF_DIRECTION |=> cfg_ff.dir == ($past(PWDATA[5:0]) | `GP_PIN3_BIT);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write wrong"); // [R2]

  property p_analog_select_bit_write;
    wr_en && PADDR == `GP_OFF_ANALOG_SEL |=> cfg_ff.analog_select_bit == ($past(PWDATA[5:0]) & `GP_MASK_NO3);
  endproperty
  a_analog_select_bit_write: assert property (p_analog_select_bit_write) else $error("analog select write wrong"); // [R14]

  property p_slew_write;
    wr_en && PADDR == `GP_OFF_SLEW_LIMIT |=> PIN_SLEW_LIMIT == ($past(PWDATA[5:0]) & `GP_MASK_NO3);
  endproperty
  a_slew_write: assert property (p_slew_write) else $error("slew limit write wrong"); // [R17]

  property p_thresh_write;
    wr_en && PADDR == `GP_OFF_THRESHOLD |=> PIN_SCHMITT_SEL == $past(PWDATA[5:0]);
  endproperty
  a_thresh_write: assert property (p_thresh_write) else $error("threshold write wrong"); // [R18]

  property p_od_write;
    wr_en && PADDR == `GP_OFF_OPEN_DRAIN |=> cfg_ff.odc == ($past(PWDATA[5:0]) & `GP_MASK_NO3);
  endproperty
  a_od_write: assert property (p_od_write) else $error("open-drain write wrong"); // [R15]

  property p_pull_write;
    ##1 ((PIN_PULLUP ^ $past(cfg_ff.wpu)) & $past(cfg_ff.dir) & `GP_MASK_NO3) == 6'h00;
  endproperty
  a_pull_write: assert property (p_pull_write) else $error("pull-up does not follow its bit"); // [R20]

  property p_out_data;
    ##1 ((PIN_OUT ^ $past(latch_ff)) & $past(~cfg_ff.dir & ~PERIPH_SEL & ~od_mode)) == 6'h00;
  endproperty
  a_out_data: assert property (p_out_data) else $error("output pin not showing latch"); // [R1]

  property p_periph_out;
    ##1 ((PIN_OUT ^ $past(PERIPH_OUT)) & $past(PERIPH_SEL & ~od_mode)) == 6'h00;
  endproperty
  a_periph_out: assert property (p_periph_out) else $error("selected pin not showing peripheral"); // [R7]

  property p_od_low;
    ##1 (PIN_OUT & $past(od_mode)) == 6'h00;
  endproperty
  a_od_low: assert property (p_od_low) else $error("open-drain pin data high"); // [R15]

  property p_od_sink;
    ##1 ($past(od_mode & ~src_out & src_drive & ~ANALOG_OUT_EN & `GP_MASK_NO3) & ~PIN_OE)
      == 6'h00;
  endproperty
  a_od_sink: assert property (p_od_sink) else $error("open-drain pin does not sink"); // [R15]

  property p_twi_od;
    ##1 (PIN_OUT & $past(TWI_OWN)) == 6'h00;
  endproperty
  a_twi_od: assert property (p_twi_od) else $error("two-wire pin data high"); // [R16]

  property p_slverr_zero;
    PREADY && PSLVERR |-> PRDATA == 32'h0000_0000;
  endproperty
  a_slverr_zero: assert property (p_slverr_zero) else $error("error answer carries data");

  property p_analog_drive;
    ##1 ($past(~cfg_ff.dir & cfg_ff.analog_select_bit & ~PERIPH_SEL & ~ANALOG_OUT_EN & ~od_mode) & ~PIN_OE) == 6'h00;
  endproperty
  a_analog_drive: assert property (p_analog_drive) else $error("analog pin output not driven"); // [R12]

  c_latch_wr: cover property (wr_en && PADDR == `GP_OFF_PIN_LEVEL);
  c_pin_read: cover property (PREADY && !$past(PWRITE) && $past(PADDR) == `GP_OFF_PIN_LEVEL);
  c_analog_override: cover property (ANALOG_OUT_EN[0] && !cfg_ff.dir[0]);
  c_twi_low: cover property (TWI_OWN[1] && PIN_OE[1]);
  c_ext_pull: cover property (EXT_RESET_EN && PIN_PULLUP[`GP_PIN3] && !cfg_ff.wpu[`GP_PIN3]);

endmodule

// file: pin_model.sv
// Purpose: Pad and far-side model for the six pins
// Assumes: Testbench picks which pins it drives from outside
// Notes: Undriven pins without pull-up toggle every cycle
`timescale 1ns/1ps
module pin_model (
  input wire logic clk,
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe,
  input wire logic [5:0] pin_pullup,
  input wire logic [5:0] ext_val,
  input wire logic [5:0] ext_en,
  output logic [5:0] pin_in
);
  logic [5:0] float_ff = 6'h2A;
  always_ff @(posedge clk) begin
    float_ff <= ~pin_in;
  end
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (ext_en[i])
        pin_in[i] = ext_val[i];
      else if (pin_pullup[i])
        pin_in[i] = 1'b1;
      else
        pin_in[i] = float_ff[i];
    end
  end
endmodule

// file: testbench.sv
// Purpose: Self-checking bench for the six-bit port
// Assumes: APB answers after one wait state
// Notes: Bus answers checked from a queue of notes
`timescale 1ns/1ps
`include "gpio_defines.svh"
module testbench;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, ext_rst = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, v;
  logic [5:0] pin_in, pin_out, pin_oe, pin_pu, pin_slew, pin_st, pin_din;
  logic [5:0] p_sel = 0, p_out = 0, p_oe = 0, twi = 0, ana_out = 0, ext_val = 0, ext_en = 6'h08;
  logic [32:0] exp_q[$];
  logic [5:0] rst_tab[7] = '{6'h00, 6'h3F, 6'h37, 6'h00, 6'h00, 6'h37, 6'h3F};
  int seed = 3795, err_total = 0, num_checks = 0, cyc = 0;
  always #20 clk = ~clk;
  six_bit_gpio_port six_bit_gpio_port_i (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
    .PSLVERR(pslverr), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .PIN_PULLUP(pin_pu),
    .PIN_SLEW_LIMIT(pin_slew), .PIN_SCHMITT_SEL(pin_st), .PIN_DIN(pin_din), .PERIPH_SEL(p_sel),
    .PERIPH_OUT(p_out), .PERIPH_OE(p_oe), .TWI_OWN(twi), .ANALOG_OUT_EN(ana_out), .EXT_RESET_EN(ext_rst));
  pin_model pin_model_i (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pu),
    .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk_bus(input logic [32:0] e, input logic [32:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR apb_answer expected %h seen %h", e, g);
    end
  endtask
  task automatic chk_pin(input string n, input logic [5:0] e, input logic [5:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [5:0] e);
    apb(1'b0, a, 32'h0, {27'h0, e});
  endtask
  always @(posedge clk) begin
    cyc++;
    if (pready === 1'b1)
      chk_bus(exp_q.size() ? exp_q.pop_front() : 33'h1FFFFFFFF, {pslverr, prdata});
    if (cyc == 5000) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk_pin("oe_reset", 6'h00, pin_oe);
    for (int i = 0; i < 7; i++) rd(8'(4 * i + 4), rst_tab[i]);
    apb(1'b0, 8'h20, 32'h0, 33'h100000000);
    wr(`GP_OFF_DIRECTION, 32'hFFFFFFC0);
    rd(`GP_OFF_DIRECTION, 6'h08);
    wr(`GP_OFF_ANALOG_SEL, 32'h0);
    for (int i = 0; i < 2; i++) begin
      v = $random(seed);
      ext_val <= v[11:6];
      wr(i ? `GP_OFF_OUT_LATCH : `GP_OFF_PIN_LEVEL, v);
      rd(`GP_OFF_OUT_LATCH, v[5:0] & 6'h37);
      chk_pin("pin_out", v[5:0] & 6'h37, pin_out);
      chk_pin("pin_oe", 6'h37, pin_oe);
      rd(`GP_OFF_PIN_LEVEL, v[5:0] & 6'h37 | v[11:6] & 6'h08);
    end
    wr(`GP_OFF_ANALOG_SEL, 32'h37);
    rd(`GP_OFF_PIN_LEVEL, v[11:6] & 6'h08);
    chk_pin("oe_analog", 6'h37, pin_oe);
    wr(`GP_OFF_OPEN_DRAIN, 32'h3F);
    repeat (2) @(posedge clk);
    chk_pin("oe_od", ~v[5:0] & 6'h37, pin_oe);
    chk_pin("out_od", 6'h00, pin_out);
    wr(`GP_OFF_OPEN_DRAIN, 32'h0);
    ana_out <= 6'h3F;
    repeat (2) @(posedge clk);
    chk_pin("oe_ana_out", 6'h00, pin_oe);
    ana_out <= 6'h00;
    p_sel <= 6'h37;
    p_oe <= 6'h37;
    p_out <= v[17:12];
    repeat (2) @(posedge clk);
    chk_pin("out_periph", v[17:12] & 6'h37, pin_out);
    twi <= 6'h37;
    repeat (2) @(posedge clk);
    chk_pin("oe_twi", ~v[17:12] & 6'h37, pin_oe);
    p_sel <= 6'h00;
    twi <= 6'h00;
    wr(`GP_OFF_PULL_UP, 32'h3F);
    repeat (2) @(posedge clk);
    chk_pin("pu_out", 6'h08, pin_pu);
    wr(`GP_OFF_DIRECTION, 32'h3F);
    repeat (2) @(posedge clk);
    chk_pin("pu_in", 6'h3F, pin_pu);
    wr(`GP_OFF_PULL_UP, 32'h0);
    ext_rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk_pin("pu_ext", 6'h08, pin_pu);
    ext_en <= 6'h3F;
    repeat (3) @(posedge clk);
    rd(`GP_OFF_PIN_LEVEL, 6'h08);
    wr(`GP_OFF_ANALOG_SEL, 32'h0);
    repeat (3) @(posedge clk);
    rd(`GP_OFF_PIN_LEVEL, v[11:6] | 6'h08);
    chk_pin("din", v[11:6] & 6'h37, pin_din & 6'h37);
    ext_rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk_pin("pu_off", 6'h00, pin_pu);
    v = $random(seed);
    wr(`GP_OFF_SLEW_LIMIT, v);
    wr(`GP_OFF_THRESHOLD, v);
    rd(`GP_OFF_THRESHOLD, v[5:0]);
    chk_pin("slew", v[5:0] & 6'h37, pin_slew);
    chk_pin("schmitt", v[5:0], pin_st);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    rd(`GP_OFF_SLEW_LIMIT, 6'h37);
    rd(`GP_OFF_OUT_LATCH, 6'h00);
    chk_pin("oe_rst2", 6'h00, pin_oe);
    print_verdict();
  end
endmodule
